// ==== oscts_pkg.sv ====
// Purpose: Shared constants for the clock source, time stamp and calibration block
// Assumes: One 100 MHz system clock; oscillators are modelled as tick enables
// Notes:   Register offsets are word indices on the plain register port
package oscts_pkg;

    localparam int          ADDR_W          = 8;
    localparam int          DATA_W          = 32;
    localparam int          NUM_GPIO        = 3;

    // Register offsets
    localparam logic [7:0]  REG_CLK_CTRL    = 8'h00;
    localparam logic [7:0]  REG_LF_TRIM     = 8'h01;
    localparam logic [7:0]  REG_HF_TRIM     = 8'h02;
    localparam logic [7:0]  REG_PIN_CFG     = 8'h03;
    localparam logic [7:0]  REG_TS_CTRL     = 8'h04;
    localparam logic [7:0]  REG_TS_COUNT    = 8'h05;
    localparam logic [7:0]  REG_SLOT_DELTA  = 8'h06;
    localparam logic [7:0]  REG_HF_CAL      = 8'h07;
    localparam logic [7:0]  REG_HF_RESULT   = 8'h08;
    localparam logic [7:0]  REG_STATUS      = 8'h09;

    // Clock control fields
    localparam int          CC_LF_EN_BIT    = 0;
    localparam int          CC_SRC_LSB      = 1;
    localparam int          CC_PIN_LSB      = 3;
    localparam int          CC_CAL_EN_BIT   = 5;
    localparam int          CC_CAL_GATE_BIT = 6;
    localparam int          CC_RUN_BIT      = 7;

    // Time stamp control fields
    localparam int          TS_ARM_BIT      = 0;
    localparam int          TS_ALWAYS_BIT   = 1;
    localparam int          TS_INV_BIT      = 2;
    localparam int          TS_PIN_LSB      = 3;

    localparam int          HFC_START_BIT   = 0;

    // Clock source select encodings
    localparam logic [1:0]  SRC_INT         = 2'h0;
    localparam logic [1:0]  SRC_EXT_LF      = 2'h1;
    localparam logic [1:0]  SRC_EXT_HF      = 2'h2;
    localparam logic [1:0]  SRC_EXT_BOTH    = 2'h3;

    // Reset values
    localparam logic [9:0]  LF_TRIM_RST     = 10'h200;
    localparam logic [7:0]  HF_TRIM_RST     = 8'h80;
    localparam logic [2:0]  PIN_CFG_RST     = 3'h0;

    // Oscillator models: phase accumulators stepping once per system clock
    localparam int          ACC_W           = 24;
    localparam logic [23:0] LF_STEP_NOM     = 24'h027525;
    localparam logic [23:0] HF_STEP_NOM     = 24'h51EB85;
    localparam int          HF_TRIM_SHIFT   = 6;

    // Counts
    localparam logic [4:0]  EXT_HF_DIV_LAST = 5'h1F;
    localparam logic [7:0]  CAL_LF_LAST     = 8'h7F;
    localparam logic [23:0] SLOT_PERIOD_LF  = 24'h0003E8;

    // Timing
    localparam int          CLK_PERIOD_NS   = 10;
    localparam int          HF_SETTLE_NS    = 1000;
    localparam logic [15:0] HF_SETTLE_CYC   =
        16'((HF_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    typedef enum logic [3:0] {
        CAL_IDLE  = 4'b0001,
        CAL_WARM  = 4'b0010,
        CAL_SYNC  = 4'b0100,
        CAL_COUNT = 4'b1000
    } oscts_cal_e;

endpackage

// ==== oscts_top.sv ====
// Purpose: Clock source selection, time stamp capture and oscillator calibration
// Assumes: gpio_in is synchronous to clk; oscillators appear as one-cycle ticks
// Notes:   An external 32 MHz clock on a pin is seen only through 100 MHz sampling
//
// Contract
// - Low-frequency base from internal 960 kHz, external pin, or external 32 MHz/32.
// - Internal low-frequency oscillator runs when enabled; 10-bit trim sets frequency.
// - Source 0x1 takes low-frequency clock from selected pin, configured as input.
// - Source 0x3 uses external 32 MHz as high clock, divided by 32 for low.
// - Sources 0x0/0x1 power internal 32 MHz only during wake-up or calibration.
// - Source 0x2 takes only the high clock externally; low clock stays internal.
// - Time stamp count holds low-frequency cycles between consecutive captured triggers.
// - Slot delta holds low-frequency cycles to next slot start, valid in go.
// - Trigger input is the pin chosen by the time stamp pin select.
// - Setting the arm bit captures on the next active trigger edge.
// - Arm bit clears after capture unless always-capture is set.
// - Trigger is edge-sensitive: rising by default, falling when inverted.
// - Capture and calibration work only while calibration circuitry is enabled.
// - Low-frequency timing works in standby; go needed only for slot delta.
// - Calibration start powers 32 MHz, settles, counts over 128 low cycles.
// - 32 MHz oscillator powers down after calibration unless slots are active.
// - Start bit clears once the calibration result is updated.
// - High-frequency trim adjusts the 32 MHz oscillator frequency.
// - With external low clock, calibration counts against that external clock.
// - Calibration clock gate resets to 0, gating calibration off.
// - Run state 0 is standby, 1 is go; entering go starts slot sequencing.
//
// The register addresses and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
module oscts_top
    import oscts_pkg::*;
(
    input  wire logic                clk,
    input  wire logic                rst,
    input  wire logic [ADDR_W-1:0]   addr,
    input  wire logic [DATA_W-1:0]   wr_data,
    input  wire logic                wr_en,
    input  wire logic                rd_en,
    output logic      [DATA_W-1:0]   rd_data,
    input  wire logic [NUM_GPIO-1:0] gpio_in,
    output logic                     lf_osc_power,
    output logic                     hf_osc_power,
    output logic                     lf_tick,
    output logic                     hf_tick,
    output logic                     slot_start
);

    // Control registers
    logic                lf_osc_enable_q;
    logic [1:0]          clock_source_select_q;
    logic [1:0]          ext_clock_pin_select_q;
    logic                cal_circuit_enable_q;
    logic                cal_clock_gate_q;
    logic                run_state_q;
    logic [9:0]          lf_osc_trim_q;
    logic [7:0]          hf_osc_trim_q;
    logic [2:0]          pin_input_config_q;
    logic                ts_arm_q;
    logic                ts_always_q;
    logic                trigger_edge_invert_q;
    logic [1:0]          ts_pin_select_q;
    logic                hf_cal_start_q;
    logic [15:0]         hf_cal_result_q;

    // Datapath state
    logic [NUM_GPIO-1:0] gpio_q;
    logic [ACC_W-1:0]    lf_acc_q;
    logic [ACC_W-1:0]    hf_acc_q;
    logic [4:0]          ext_div_q;
    logic                lf_tick_q;
    logic                hf_tick_q;
    logic                hf_osc_power_q;
    logic [23:0]         ts_interval_q;
    logic [23:0]         ts_count_q;
    logic [23:0]         slot_delta_q;
    logic [23:0]         slot_cnt_q;
    logic                run_prev_q;
    logic                slot_start_q;
    logic                trig_prev_q;
    oscts_cal_e          cal_state_q;
    logic [15:0]         settle_cnt_q;
    logic [7:0]          cal_lf_cnt_q;
    logic [15:0]         cal_hf_cnt_q;
    logic [DATA_W-1:0]   rd_data_q;

    logic [NUM_GPIO-1:0] gpio_ok;
    logic                ext_lvl;
    logic                ext_rise;
    logic [ACC_W:0]      lf_sum;
    logic [ACC_W:0]      hf_sum;
    logic [ACC_W-1:0]    lf_step;
    logic [ACC_W-1:0]    hf_step;
    logic                lf_tick_d;
    logic                hf_tick_d;
    logic                cal_active;
    logic                trig_lvl;
    logic                capture;
    logic                cal_done;
    logic                wr_clk;
    logic                wr_ts;
    logic                wr_cal;

    assign wr_clk     = wr_en && (addr == REG_CLK_CTRL);
    assign wr_ts      = wr_en && (addr == REG_TS_CTRL);
    assign wr_cal     = wr_en && (addr == REG_HF_CAL);
    assign cal_active = cal_circuit_enable_q && cal_clock_gate_q;

    // Pins only count as inputs when configured so
    assign gpio_ok  = gpio_in & pin_input_config_q;
    assign ext_lvl  = gpio_ok[ext_clock_pin_select_q];
    assign ext_rise = ext_lvl && !gpio_q[ext_clock_pin_select_q];

    // Edge found on the raw pin, so flipping polarity never fakes an edge
    assign trig_lvl = gpio_ok[ts_pin_select_q];
    assign capture  = (trigger_edge_invert_q ? (!trig_lvl && trig_prev_q)
                                             : (trig_lvl && !trig_prev_q))
                      && ts_arm_q && cal_active;

    // Oscillator models: trim moves the accumulator step around its nominal
    assign lf_step = ACC_W'(LF_STEP_NOM + {14'h0000, lf_osc_trim_q}
                     - {14'h0000, LF_TRIM_RST});
    assign hf_step = ACC_W'(HF_STEP_NOM + ({16'h0000, hf_osc_trim_q} << HF_TRIM_SHIFT)
                     - ({16'h0000, HF_TRIM_RST} << HF_TRIM_SHIFT));
    assign lf_sum  = {1'b0, lf_acc_q} + {1'b0, lf_step};
    assign hf_sum  = {1'b0, hf_acc_q} + {1'b0, hf_step};

    always_comb
    begin
        case (clock_source_select_q)
            SRC_EXT_LF:   lf_tick_d = ext_rise;
            SRC_EXT_BOTH: lf_tick_d = ext_rise && (ext_div_q == EXT_HF_DIV_LAST);
            default:      lf_tick_d = lf_osc_enable_q && lf_sum[ACC_W];
        endcase
        if (clock_source_select_q[1])
        begin
            hf_tick_d = ext_rise;
        end
        else
        begin
            hf_tick_d = hf_osc_power_q && hf_sum[ACC_W];
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            gpio_q      <= '0;
            trig_prev_q <= 1'b0;
        end
        else
        begin
            gpio_q      <= gpio_ok;
            trig_prev_q <= trig_lvl;
        end
    end

    // Internal oscillator accumulators and external divide by 32
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            lf_acc_q  <= '0;
            hf_acc_q  <= '0;
            ext_div_q <= '0;
            lf_tick_q <= 1'b0;
            hf_tick_q <= 1'b0;
        end
        else
        begin
            if (lf_osc_enable_q)
            begin
                lf_acc_q <= lf_sum[ACC_W-1:0];
            end
            if (hf_osc_power_q)
            begin
                hf_acc_q <= hf_sum[ACC_W-1:0];
            end
            if (clock_source_select_q == SRC_EXT_BOTH && ext_rise)
            begin
                ext_div_q <= ext_div_q + 5'h01;
            end
            lf_tick_q <= lf_tick_d;
            hf_tick_q <= hf_tick_d;
        end
    end

    // Internal 32 MHz power: only for wake-up in go or for calibration
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            hf_osc_power_q <= 1'b0;
        end
        else
        begin
            hf_osc_power_q <= !clock_source_select_q[1]
                              && (run_state_q || cal_state_q != CAL_IDLE);
        end
    end

    // Clock control register
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            lf_osc_enable_q        <= 1'b0;
            clock_source_select_q  <= SRC_INT;
            ext_clock_pin_select_q <= 2'h0;
            cal_circuit_enable_q   <= 1'b0;
            cal_clock_gate_q       <= 1'b0;
            run_state_q            <= 1'b0;
        end
        else if (wr_clk)
        begin
            lf_osc_enable_q        <= wr_data[CC_LF_EN_BIT];
            clock_source_select_q  <= wr_data[CC_SRC_LSB +: 2];
            ext_clock_pin_select_q <= wr_data[CC_PIN_LSB +: 2];
            cal_circuit_enable_q   <= wr_data[CC_CAL_EN_BIT];
            cal_clock_gate_q       <= wr_data[CC_CAL_GATE_BIT];
            run_state_q            <= wr_data[CC_RUN_BIT];
        end
    end

    // Trim and pin configuration registers
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            lf_osc_trim_q      <= LF_TRIM_RST;
            hf_osc_trim_q      <= HF_TRIM_RST;
            pin_input_config_q <= PIN_CFG_RST;
        end
        else if (wr_en)
        begin
            if (addr == REG_LF_TRIM)
            begin
                lf_osc_trim_q <= wr_data[9:0];
            end
            if (addr == REG_HF_TRIM)
            begin
                hf_osc_trim_q <= wr_data[7:0];
            end
            if (addr == REG_PIN_CFG)
            begin
                pin_input_config_q <= wr_data[2:0];
            end
        end
    end

    // Time stamp control; a software arm in the capture cycle wins
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            ts_arm_q              <= 1'b0;
            ts_always_q           <= 1'b0;
            trigger_edge_invert_q <= 1'b0;
            ts_pin_select_q       <= 2'h0;
        end
        else
        begin
            if (wr_ts)
            begin
                ts_always_q           <= wr_data[TS_ALWAYS_BIT];
                trigger_edge_invert_q <= wr_data[TS_INV_BIT];
                ts_pin_select_q       <= wr_data[TS_PIN_LSB +: 2];
            end
            if (wr_ts && wr_data[TS_ARM_BIT])
            begin
                ts_arm_q <= 1'b1;
            end
            else if (wr_ts)
            begin
                ts_arm_q <= 1'b0;
            end
            else if (capture && !ts_always_q)
            begin
                ts_arm_q <= 1'b0;
            end
        end
    end

    // Interval counter in low-frequency cycles, restarted at each capture
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            ts_interval_q <= '0;
            ts_count_q    <= '0;
            slot_delta_q  <= '0;
        end
        else if (capture)
        begin
            ts_count_q    <= ts_interval_q + {23'h000000, lf_tick_q};
            ts_interval_q <= '0;
            slot_delta_q  <= run_state_q ? (slot_cnt_q + 24'h000001) : '0;
        end
        else if (lf_tick_q && cal_active)
        begin
            ts_interval_q <= ts_interval_q + 24'h000001;
        end
    end

    // Slot sequencing: standby holds it reset, entering go starts a slot at once
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            run_prev_q   <= 1'b0;
            slot_cnt_q   <= '0;
            slot_start_q <= 1'b0;
        end
        else
        begin
            run_prev_q   <= run_state_q;
            slot_start_q <= 1'b0;
            if (!run_state_q)
            begin
                slot_cnt_q <= '0;
            end
            else if (!run_prev_q)
            begin
                slot_start_q <= 1'b1;
                slot_cnt_q   <= SLOT_PERIOD_LF - 24'h000001;
            end
            else if (lf_tick_q)
            begin
                if (slot_cnt_q == '0)
                begin
                    slot_start_q <= 1'b1;
                    slot_cnt_q   <= SLOT_PERIOD_LF - 24'h000001;
                end
                else
                begin
                    slot_cnt_q <= slot_cnt_q - 24'h000001;
                end
            end
        end
    end

    // High-frequency calibration sequencer
    assign cal_done = (cal_state_q == CAL_COUNT) && lf_tick_q && (cal_lf_cnt_q == CAL_LF_LAST);

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cal_state_q  <= CAL_IDLE;
            settle_cnt_q <= '0;
            cal_lf_cnt_q <= '0;
            cal_hf_cnt_q <= '0;
        end
        else if (!cal_active)
        begin
            cal_state_q <= CAL_IDLE;
        end
        else
        begin
            case (cal_state_q)
                CAL_IDLE:
                begin
                    if (hf_cal_start_q)
                    begin
                        cal_state_q  <= CAL_WARM;
                        settle_cnt_q <= '0;
                    end
                end
                CAL_WARM:
                begin
                    settle_cnt_q <= settle_cnt_q + 16'h0001;
                    if (settle_cnt_q == HF_SETTLE_CYC - 16'h0001)
                    begin
                        cal_state_q <= CAL_SYNC;
                    end
                end
                CAL_SYNC:
                begin
                    if (lf_tick_q)
                    begin
                        cal_state_q  <= CAL_COUNT;
                        cal_lf_cnt_q <= '0;
                        cal_hf_cnt_q <= '0;
                    end
                end
                CAL_COUNT:
                begin
                    if (hf_tick_q)
                    begin
                        cal_hf_cnt_q <= cal_hf_cnt_q + 16'h0001;
                    end
                    if (lf_tick_q)
                    begin
                        cal_lf_cnt_q <= cal_lf_cnt_q + 8'h01;
                    end
                    if (cal_done)
                    begin
                        cal_state_q <= CAL_IDLE;
                    end
                end
                default:
                begin
                    cal_state_q <= CAL_IDLE;
                end
            endcase
        end
    end

    // Result load and start bit; a software start in the done cycle wins
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            hf_cal_start_q  <= 1'b0;
            hf_cal_result_q <= '0;
        end
        else
        begin
            if (cal_done)
            begin
                hf_cal_result_q <= cal_hf_cnt_q + {15'h0000, hf_tick_q};
            end
            if (wr_cal && wr_data[HFC_START_BIT])
            begin
                hf_cal_start_q <= 1'b1;
            end
            else if (cal_done)
            begin
                hf_cal_start_q <= 1'b0;
            end
        end
    end

    // Register read port: data one cycle after the strobe, zero otherwise
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            rd_data_q <= '0;
        end
        else if (rd_en)
        begin
            case (addr)
                REG_CLK_CTRL:   rd_data_q <= {24'h000000, run_state_q, cal_clock_gate_q,
                                              cal_circuit_enable_q, ext_clock_pin_select_q,
                                              clock_source_select_q, lf_osc_enable_q};
                REG_LF_TRIM:    rd_data_q <= {22'h000000, lf_osc_trim_q};
                REG_HF_TRIM:    rd_data_q <= {24'h000000, hf_osc_trim_q};
                REG_PIN_CFG:    rd_data_q <= {29'h00000000, pin_input_config_q};
                REG_TS_CTRL:    rd_data_q <= {27'h0000000, ts_pin_select_q,
                                              trigger_edge_invert_q, ts_always_q, ts_arm_q};
                REG_TS_COUNT:   rd_data_q <= {8'h00, ts_count_q};
                REG_SLOT_DELTA: rd_data_q <= {8'h00, slot_delta_q};
                REG_HF_CAL:     rd_data_q <= {31'h00000000, hf_cal_start_q};
                REG_HF_RESULT:  rd_data_q <= {16'h0000, hf_cal_result_q};
                REG_STATUS:     rd_data_q <= {28'h0000000, run_state_q,
                                              (cal_state_q != CAL_IDLE), cal_active,
                                              hf_osc_power_q};
                default:        rd_data_q <= '0;
            endcase
        end
        else
        begin
            rd_data_q <= '0;
        end
    end

    assign rd_data      = rd_data_q;
    assign lf_osc_power = lf_osc_enable_q;
    assign hf_osc_power = hf_osc_power_q;
    assign lf_tick      = lf_tick_q;
    assign hf_tick      = hf_tick_q;
    assign slot_start   = slot_start_q;

endmodule

// ==== oscts_sva.sv ====
// Purpose: Port checker for oscts_top
// Assumes: Clock control is shadowed from bus writes
// Notes:   Bound at the foot of this file
`timescale 1ns/1ps
module oscts_sva
    import oscts_pkg::*;
(
    input wire logic              clk,
    input wire logic              rst,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wr_data,
    input wire logic              wr_en,
    input wire logic              rd_en,
    input wire logic [DATA_W-1:0] rd_data,
    input wire logic              lf_osc_power,
    input wire logic              hf_osc_power,
    input wire logic              lf_tick,
    input wire logic              hf_tick,
    input wire logic              slot_start
);
    logic [7:0] cc_q;
    logic       busy_q;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    always_ff @(posedge clk or posedge rst)
        if (rst)
            cc_q <= 8'h00;
        else if (wr_en && addr == REG_CLK_CTRL)
            cc_q <= wr_data[7:0];
    // Set once anything may legally power the high oscillator
    always_ff @(posedge clk or posedge rst)
        if (rst)
            busy_q <= 1'b0;
        else if (wr_en && (addr == REG_HF_CAL || (addr == REG_CLK_CTRL && wr_data[7])))
            busy_q <= 1'b1;
    a_ctrl_read_back: assert property (rd_en && addr == REG_CLK_CTRL |=> rd_data[7:0] == cc_q)
        else $error("clock control read back differs");
    a_lf_power_follow: assert property (wr_en && addr == REG_CLK_CTRL |-> ##2 lf_osc_power == cc_q[0])
        else $error("low oscillator power not following enable");
    a_lf_off_still: assert property ((!cc_q[0] && !cc_q[1]) [*4] |-> !lf_tick)
        else $error("low tick while internal oscillator off");
    a_lf_tick_single: assert property (lf_tick |=> !lf_tick)
        else $error("low tick longer than one cycle");
    a_slot_single: assert property (slot_start |=> !slot_start)
        else $error("slot start longer than one cycle");
    a_standby_quiet: assert property (!cc_q[7] [*4] |-> !slot_start)
        else $error("slot start in standby");
    a_hf_off_quiet: assert property (!busy_q |-> !hf_osc_power)
        else $error("high oscillator powered without cause");
    a_cal_power_up: assert property (wr_en && addr == REG_HF_CAL && wr_data[0] && cc_q[6:5] == 2'h3
        && !cc_q[2] |-> ##[1:4] hf_osc_power)
        else $error("calibration did not power high oscillator");
    a_hf_tick_gated: assert property ((!cc_q[2] && !hf_osc_power) [*3] |-> !hf_tick)
        else $error("high tick while oscillator off");
    c_slot: cover property (slot_start);
    c_hf_on: cover property ($rose(hf_osc_power));
    c_lf: cover property (lf_tick);
endmodule
bind oscts_top oscts_sva u_sva (.clk(clk), .rst(rst), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .lf_osc_power(lf_osc_power),
    .hf_osc_power(hf_osc_power), .lf_tick(lf_tick), .hf_tick(hf_tick),
    .slot_start(slot_start));

// ==== oscts_host.sv ====
// Purpose: Host driving external clock and trigger pins
// Assumes: Pin 0 low clock of 20 cycles, pin 1 trigger of 400 cycles
// Notes:   Both run continuously, aligned to each other
`timescale 1ns/1ps
module oscts_host
(
    input  wire logic clk,
    output logic [2:0] gpio
);
    int unsigned n = 0;
    always @(posedge clk)
    begin
        n <= n + 1;
        gpio[0] <= (n % 20) < 10; // External low clock never stops
        gpio[1] <= (n % 400) < 200; // Trigger of known period for time stamps
        gpio[2] <= n[0]; // Fast external clock for the divide by 32 path
    end
endmodule

// ==== test_osc_select_timestamp_cal.sv ====
// Purpose: Self-checking bench for oscts_top
// Assumes: External low clock on pin 0, trigger on pin 1
// Notes:   Twenty system cycles per low clock cycle
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin mismatches++; \
    $display("Error %0t: got %0h want %0h", $time, a, b); end end
module test_osc_select_timestamp_cal;
    import oscts_pkg::*;
    logic                clk;
    logic                rst;
    logic                wr_en;
    logic                rd_en;
    logic                hf_osc_power;
    logic                slot_start;
    logic [ADDR_W-1:0]   addr;
    logic [DATA_W-1:0]   wr_data;
    logic [DATA_W-1:0]   rd_data;
    logic [DATA_W-1:0]   d;
    logic [NUM_GPIO-1:0] gpio_in;
    int                  tests_run = 0;
    int                  mismatches = 0;
    int                  cyc = 0;
    oscts_top uut (.clk(clk), .rst(rst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
        .rd_en(rd_en), .rd_data(rd_data), .gpio_in(gpio_in), .lf_osc_power(),
        .hf_osc_power(hf_osc_power), .lf_tick(), .hf_tick(), .slot_start(slot_start));
    oscts_host host (.clk(clk), .gpio(gpio_in));
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        addr <= a;
        wr_data <= v;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1 d = rd_data;
        @(posedge clk);
    endtask
    task automatic t_reset_values;
        rd(REG_CLK_CTRL);
        `CHK(d, 32'h0)
        rd(REG_LF_TRIM);
        `CHK(d, 32'h200)
        rd(REG_HF_TRIM);
        `CHK(d, 32'h80)
        rd(8'hFF);
        `CHK(d, 32'h0)
        wr(REG_LF_TRIM, 32'hFFFFFFFF); // Host retunes the low oscillator
        rd(REG_LF_TRIM);
        `CHK(d, 32'h3FF)
        wr(REG_LF_TRIM, {22'h0, LF_TRIM_RST});
    endtask
    task automatic t_timestamp;
        wr(REG_PIN_CFG, 32'h3);
        wr(REG_CLK_CTRL, 32'h23);
        wr(REG_TS_CTRL, 32'h9);
        repeat (900) @(posedge clk);
        rd(REG_TS_CTRL);
        `CHK(d[0], 1'b1)
        wr(REG_CLK_CTRL, 32'h63);
        wr(REG_TS_CTRL, 32'hB);
        repeat (900) @(posedge clk);
        rd(REG_TS_COUNT);
        `CHK(d, 32'h14)
        rd(REG_TS_CTRL);
        `CHK(d[0], 1'b1)
        wr(REG_TS_CTRL, 32'hD);
        repeat (900) @(posedge clk);
        rd(REG_TS_CTRL);
        `CHK(d[0], 1'b0)
        rd(REG_TS_COUNT);
        `CHK(d inside {32'hA, 32'h1E}, 1'b1)
    endtask
    task automatic cal(output logic [31:0] res);
        wr(REG_HF_CAL, 32'h1);
        d = 32'h1;
        for (int i = 0; i < 100 && d[0]; i++)
        begin
            repeat (100) @(posedge clk);
            rd(REG_HF_CAL);
        end
        `CHK(d[0], 1'b0)
        rd(REG_HF_RESULT);
        res = d;
        #1;
        `CHK(hf_osc_power, 1'b0)
        @(posedge clk);
    endtask
    task automatic t_hf_cal;
        longint      exp_cnt;
        logic [31:0] r1;
        logic [31:0] r2;
        logic [31:0] r3;
        exp_cnt = (longint'(2560) * HF_STEP_NOM) >> ACC_W;
        cal(r1);
        `CHK(r1 inside {[exp_cnt - 1 : exp_cnt + 1]}, 1'b1)
        wr(REG_HF_TRIM, 32'hFF);
        cal(r2);
        wr(REG_HF_TRIM, 32'h0);
        cal(r3);
        `CHK(r2 > r3, 1'b1)
        wr(REG_HF_TRIM, {24'h0, HF_TRIM_RST});
        wr(REG_PIN_CFG, 32'h7);
        wr(REG_CLK_CTRL, 32'h77);
        cal(r1);
        `CHK(r1, 32'h1000)
        wr(REG_CLK_CTRL, 32'h63);
    endtask
    task automatic t_slots;
        int n;
        wr(REG_TS_CTRL, 32'hB);
        wr(REG_CLK_CTRL, 32'hE3);
        n = 0;
        while (slot_start !== 1'b1 && n < 20)
        begin
            @(negedge clk);
            n++;
        end
        `CHK(slot_start, 1'b1)
        repeat (420) @(posedge clk);
        rd(REG_SLOT_DELTA);
        `CHK(d inside {[32'h3C0 : 32'h3E8]}, 1'b1)
        `CHK(hf_osc_power, 1'b1)
        wr(REG_CLK_CTRL, 32'hF5);
        @(negedge clk);
        `CHK(hf_osc_power, 1'b0)
        @(posedge clk);
        wr(REG_CLK_CTRL, 32'h63);
        repeat (420) @(posedge clk);
        rd(REG_SLOT_DELTA);
        `CHK(d, 32'h0)
    endtask
    task automatic final_report;
        $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 30000)
        begin
            mismatches++;
            final_report;
        end
    end
    initial
    begin
        rst = 1'b1;
        wr_en = 1'b0;
        rd_en = 1'b0;
        addr = '0;
        wr_data = '0;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset_values;
        t_timestamp;
        t_hf_cal;
        t_slots;
        final_report;
    end
endmodule
